// ==== design/lrm_pkg.sv ====
package lrm_pkg;

  // ****************************************************************
  // Storage geometry
  // ****************************************************************
  localparam int LOC_W       = 6;
  localparam int BYTE_W      = 8;
  localparam int DEPTH       = 64;
  localparam int GROUPS      = 4;
  localparam int GROUP_SIZE  = 16;
  localparam int GSEL_W      = 4;

  // ****************************************************************
  // Pin map
  // ****************************************************************
  localparam int PIN_LOC_LSB = 0;
  localparam int PIN_REQ_BIT = 7;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_SRC_BIT    = 0;
  localparam int CMD_LOC_LSB     = 0;
  localparam int CMD_BYTE_LSB    = 8;
  localparam int CMD_REQ_BIT     = 16;
  localparam int STAT_BYTE_LSB   = 0;
  localparam int STAT_PEND_BIT   = 8;
  localparam int STAT_ARMED_BIT  = 9;
  localparam int STAT_WINDOW_BIT = 10;
  localparam int STAT_DROP_BIT   = 11;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] ZERO_WORD_RST = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [7:0]  OE_RST        = 8'hff;
  localparam logic [5:0]  LOC_RST       = 6'h00;
  localparam logic [3:0]  GRP_EN_RST    = 4'h1;

endpackage

// ==== design/lrm_byte_cell.sv ====
`timescale 1ns/1ps

module lrm_byte_cell
#(
  parameter logic [5:0] INDEX = 6'h00
)
(
  input  wire logic [5:0] wr_loc,
  input  wire logic       armed,
  input  wire logic       window,
  input  wire logic [7:0] wr_byte,
  output logic            gate,
  output logic [7:0]      q
);

  logic match;

  assign match = (wr_loc == INDEX);
  assign gate  = armed & window & match;

  // Eight transparent cells; no reset so contents survive reset
  always_latch
  begin
    if (gate)
      q <= wr_byte;
  end

endmodule

// ==== design/lrm_group_mux.sv ====
`timescale 1ns/1ps

module lrm_group_mux
#(
  parameter int SIZE = 16,
  parameter int SEL_W = 4
)
(
  input  wire logic [SIZE*8-1:0] bytes,
  input  wire logic [SEL_W-1:0]  sel,
  input  wire logic              en,
  output logic [7:0]             drive
);

  initial
  begin
    if (SIZE != (1 << SEL_W))
      $error("lrm_group_mux: SIZE must be 2**SEL_W");
  end

  logic [7:0] picked;

  assign picked = bytes[sel*8 +: 8];
  // Disabled buffer contributes nothing to the shared wire
  assign drive  = en ? picked : 8'h00;

endmodule

// ==== design/lrm_latch_ram.sv ====
`timescale 1ns/1ps

module lrm_latch_ram
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  ui_in,
  input  wire logic [7:0]  uio_in,
  output logic [7:0]       uo_out,
  output logic [7:0]       uio_out,
  output logic [7:0]       uio_oe
);

  localparam int LW = lrm_pkg::LOC_W;
  localparam int BW = lrm_pkg::BYTE_W;
  localparam int NG = lrm_pkg::GROUPS;
  localparam int GS = lrm_pkg::GROUP_SIZE;

  initial
  begin
    if (lrm_pkg::DEPTH != NG * GS || lrm_pkg::DEPTH != (1 << LW))
      $error("lrm_latch_ram: geometry does not match location width");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [7:0] ui_meta_reg;
  logic [7:0] ui_sync_reg;
  logic [7:0] uio_meta_reg;
  logic [7:0] uio_sync_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ui_meta_reg  <= lrm_pkg::BYTE_RST;
      ui_sync_reg  <= lrm_pkg::BYTE_RST;
      uio_meta_reg <= lrm_pkg::BYTE_RST;
      uio_sync_reg <= lrm_pkg::BYTE_RST;
    end
    else
    begin
      ui_meta_reg  <= ui_in;
      ui_sync_reg  <= ui_meta_reg;
      uio_meta_reg <= uio_in;
      uio_sync_reg <= uio_meta_reg;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic          src_apb_reg;
  logic [LW-1:0] cmd_loc_reg;
  logic [BW-1:0] cmd_byte_reg;
  logic          cmd_req_reg;
  logic          drop_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic [31:0]   prdata_reg;
  logic          pending_reg;
  logic          armed_reg;
  logic          window_reg;
  logic [BW-1:0] out_reg;

  wire setup_phase = psel & ~penable;
  wire commit      = psel & penable & pready_reg;
  wire hit_ctrl    = (paddr == lrm_pkg::CTRL_OFS);
  wire hit_cmd     = (paddr == lrm_pkg::CMD_OFS);
  wire hit_status  = (paddr == lrm_pkg::STATUS_OFS);
  wire hit_any     = hit_ctrl | hit_cmd | hit_status;
  wire wr_ctrl     = commit & pwrite & hit_ctrl;
  wire wr_cmd      = commit & pwrite & hit_cmd;

  wire [31:0] ctrl_word = {31'h0, src_apb_reg};
  wire [31:0] cmd_word  = {16'h0, cmd_byte_reg, 2'h0, cmd_loc_reg};
  wire [31:0] stat_word = {20'h0, drop_reg, window_reg, armed_reg,
                           pending_reg, out_reg};
  wire [31:0] rd_word   = hit_ctrl   ? ctrl_word :
                          hit_cmd    ? cmd_word  :
                          hit_status ? stat_word : 32'h0;

  // Data is prepared in setup, so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= lrm_pkg::ZERO_WORD_RST;
    end
    else
    begin
      pready_reg  <= setup_phase;
      pslverr_reg <= setup_phase & ~hit_any;
      prdata_reg  <= (setup_phase & ~pwrite) ? rd_word : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_apb_reg  <= 1'b0;
      cmd_loc_reg  <= lrm_pkg::LOC_RST;
      cmd_byte_reg <= lrm_pkg::BYTE_RST;
      cmd_req_reg  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        src_apb_reg <= pwdata[lrm_pkg::CTRL_SRC_BIT];
      if (wr_cmd)
      begin
        cmd_loc_reg  <= pwdata[lrm_pkg::CMD_LOC_LSB +: LW];
        cmd_byte_reg <= pwdata[lrm_pkg::CMD_BYTE_LSB +: BW];
      end
      cmd_req_reg <= wr_cmd & pwdata[lrm_pkg::CMD_REQ_BIT];
    end
  end

  // ****************************************************************
  // Request source
  // ****************************************************************
  wire [LW-1:0] pin_loc  = ui_sync_reg[lrm_pkg::PIN_LOC_LSB +: LW];
  wire          pin_req  = ui_sync_reg[lrm_pkg::PIN_REQ_BIT];
  wire [LW-1:0] loc_in   = src_apb_reg ? cmd_loc_reg  : pin_loc;
  wire [BW-1:0] byte_in  = src_apb_reg ? cmd_byte_reg : uio_sync_reg;
  wire          req_in   = src_apb_reg ? cmd_req_reg  : pin_req;
  wire          accept   = req_in & ~pending_reg;
  wire          dropped  = req_in & pending_reg;

  // ****************************************************************
  // Write control
  // ****************************************************************
  logic [LW-1:0] wr_loc_reg;
  logic [BW-1:0] captured_write_byte_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_reg             <= 1'b0;
      armed_reg               <= 1'b0;
      wr_loc_reg              <= lrm_pkg::LOC_RST;
      captured_write_byte_reg <= lrm_pkg::BYTE_RST;
      drop_reg                <= 1'b0;
    end
    else
    begin
      pending_reg <= accept;
      armed_reg   <= pending_reg;
      if (accept)
      begin
        wr_loc_reg              <= loc_in;
        captured_write_byte_reg <= byte_in;
      end
      if (dropped)
        drop_reg <= 1'b1;
      else if (wr_ctrl)
        drop_reg <= 1'b0;
    end
  end

  // Window closes half a cycle after arming, so gates open one half
  always_ff @(negedge pclk or negedge presetn)
  begin
    if (!presetn)
      window_reg <= 1'b1;
    else
      window_reg <= ~armed_reg;
  end

  // ****************************************************************
  // Storage array
  // ****************************************************************
  logic [lrm_pkg::DEPTH*BW-1:0] mem_flat;
  logic [lrm_pkg::DEPTH-1:0]    gate_vec;

  for (genvar i = 0; i < lrm_pkg::DEPTH; i++)
  begin : g_cell
    lrm_byte_cell #(
      .INDEX (LW'(i))
    ) u_cell (
      .wr_loc  (wr_loc_reg),
      .armed   (armed_reg),
      .window  (window_reg),
      .wr_byte (captured_write_byte_reg),
      .gate    (gate_vec[i]),
      .q       (mem_flat[i*BW +: BW])
    );
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [LW-1:0] rd_loc_reg;
  logic [NG-1:0] grp_en_reg;
  logic [BW-1:0] grp_drive [NG];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_loc_reg <= lrm_pkg::LOC_RST;
      grp_en_reg <= lrm_pkg::GRP_EN_RST;
    end
    else
    begin
      rd_loc_reg <= loc_in;
      grp_en_reg <= NG'(1) << loc_in[LW-1 -: 2];
    end
  end

  for (genvar g = 0; g < NG; g++)
  begin : g_grp
    lrm_group_mux #(
      .SIZE  (GS),
      .SEL_W (lrm_pkg::GSEL_W)
    ) u_mux (
      .bytes (mem_flat[g*GS*BW +: GS*BW]),
      .sel   (rd_loc_reg[lrm_pkg::GSEL_W-1:0]),
      .en    (grp_en_reg[g]),
      .drive (grp_drive[g])
    );
  end

  wire [BW-1:0] shared_wire = grp_drive[0] | grp_drive[1] |
                              grp_drive[2] | grp_drive[3];

  // Rebuffer: sampled mid-cycle so a byte written this cycle shows
  always_ff @(negedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_reg <= lrm_pkg::BYTE_RST;
    else
      out_reg <= shared_wire;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic [BW-1:0] uio_oe_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uio_oe_reg <= lrm_pkg::OE_RST;
    else
      uio_oe_reg <= lrm_pkg::OE_RST;
  end

  assign uo_out  = out_reg;
  assign uio_out = lrm_pkg::BYTE_RST;
  assign uio_oe  = uio_oe_reg;
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pend_single;
    @(posedge pclk) disable iff (!presetn)
      pending_reg |=> !pending_reg;
  endproperty
  a_pend_single: assert property (p_pend_single)
    else $error("pending write lasted more than one cycle");

  property p_capture;
    @(posedge pclk) disable iff (!presetn)
      (req_in && !pending_reg) |=>
        pending_reg && wr_loc_reg == $past(loc_in) &&
        captured_write_byte_reg == $past(byte_in);
  endproperty
  a_capture: assert property (p_capture)
    else $error("write request not captured");

  property p_loc_hold;
    @(posedge pclk) disable iff (!presetn)
      $rose(pending_reg) |=> $stable(wr_loc_reg) ##1 1'b1;
  endproperty
  a_loc_hold: assert property (p_loc_hold)
    else $error("write location moved during write");

  property p_discard;
    @(posedge pclk) disable iff (!presetn)
      (req_in && pending_reg) |=>
        $stable(captured_write_byte_reg) && $stable(wr_loc_reg) &&
        !pending_reg;
  endproperty
  a_discard: assert property (p_discard)
    else $error("request during pending write was not dropped");

  property p_arm;
    @(posedge pclk) disable iff (!presetn)
      armed_reg == $past(pending_reg, 1);
  endproperty
  a_arm: assert property (p_arm)
    else $error("armed flag does not follow pending flag");

  property p_window_open;
    @(posedge pclk) disable iff (!presetn)
      pending_reg |-> window_reg ##1 (armed_reg && !window_reg);
  endproperty
  a_window_open: assert property (p_window_open)
    else $error("write window wrong around arming");

  property p_gate_one;
    @(negedge pclk) disable iff (!presetn)
      $onehot0(gate_vec) && (!(armed_reg && window_reg) ||
        gate_vec[wr_loc_reg]);
  endproperty
  a_gate_one: assert property (p_gate_one)
    else $error("latch gates not limited to addressed byte");

  property p_grp_en;
    @(posedge pclk) disable iff (!presetn)
      ##1 $onehot(grp_en_reg) &&
        grp_en_reg[rd_loc_reg[LW-1 -: 2]];
  endproperty
  a_grp_en: assert property (p_grp_en)
    else $error("group enable disagrees with read location");

  property p_rd_loc;
    @(posedge pclk) disable iff (!presetn)
      ##1 rd_loc_reg == $past(loc_in);
  endproperty
  a_rd_loc: assert property (p_rd_loc)
    else $error("read location not loaded from inputs");

endmodule

// ==== tb/lrm_pin_host.sv ====
`timescale 1ns/1ps

module lrm_pin_host
(
  input  wire logic       pclk,
  input  wire logic [7:0] uo_out,
  output logic [7:0]      ui_in,
  output logic [7:0]      uio_in
);

  // ****************
  // Pin host
  // ****************
  initial
  begin
    ui_in  = 8'h00;
    uio_in = 8'h5a;
  end

  // Request held two cycles only when a refused write is wanted
  task automatic write(input logic [5:0] loc, input logic [7:0] b1,
                       input logic [7:0] b2, input bit twice);
    @(posedge pclk);
    ui_in  <= {1'b1, 1'b0, loc};
    uio_in <= b1;
    if (twice)
    begin
      @(posedge pclk);
      uio_in <= b2;
    end
    @(posedge pclk);
    ui_in[7] <= 1'b0;
    uio_in   <= ~uio_in;
    repeat (6) @(posedge pclk);
  endtask

  task automatic read(input logic [5:0] loc, output logic [7:0] q);
    @(posedge pclk);
    ui_in <= {1'b0, 1'b0, loc};
    repeat (6) @(posedge pclk);
    q = uo_out;
  endtask
endmodule

// ==== tb/test_latch_ram_64_byte.sv ====
`timescale 1ns/1ps

module test_latch_ram_64_byte;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  ui_in;
  logic [7:0]  uio_in;
  logic [7:0]  uo_out;
  logic [7:0]  uio_out;
  logic [7:0]  uio_oe;
  int          error_cnt;
  int          checks_done;
  logic [7:0]  mem [int];

  lrm_latch_ram dut
  (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .ui_in   (ui_in),
    .uio_in  (uio_in),
    .uo_out  (uo_out),
    .uio_out (uio_out),
    .uio_oe  (uio_oe)
  );

  lrm_pin_host host
  (
    .pclk   (pclk),
    .uo_out (uo_out),
    .ui_in  (ui_in),
    .uio_in (uio_in)
  );

  // ****************
  // Helpers
  // ****************
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x,
                     input string m);
    checks_done++;
    if (g !== x)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [31:0] cmd_word(input logic [5:0] l,
                                           input logic [7:0] b,
                                           input logic r);
    cmd_word = {15'h0000, r, b, 2'b00, l};
  endfunction

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 32);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic verify_all(input string m);
    logic [7:0] b;
    foreach (mem[k])
    begin
      host.read(6'(k), b);
      chk(b, mem[k], m);
    end
    $display("test %s done", m);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic [7:0]  b;
    logic [5:0]  l;
    int          s;
    error_cnt   = 0;
    checks_done = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    s = $urandom(20335);
    repeat (8) @(posedge pclk);
    chk(uio_oe, 8'hff, "oe");
    chk(uio_out, 8'h00, "uio out");
    chk(uo_out, 8'h00, "out");
    presetn <= 1'b1;
    apb(lrm_pkg::CTRL_OFS, 1'b0, 32'h0, q, e);
    chk(q, 32'h0, "ctrl reset");
    apb(8'h0c, 1'b1, 32'hffff_ffff, q, e);
    chk(e, 1'b1, "unmapped write");
    apb(8'h0c, 1'b0, 32'h0, q, e);
    chk(q, 32'h0, "unmapped read data");
    chk(32'(e), 32'h1, "unmapped read error");
    $display("test regs done");
    for (int i = 0; i < 16; i++)
    begin
      l = (i < 2) ? 6'(i * 63) : 6'($urandom);
      mem[l] = 8'($urandom);
      host.write(l, mem[l], 8'h00, 1'b0);
      host.read(l, b);
      chk(b, mem[l], "new byte");
    end
    verify_all("pins");
    l = 6'($urandom);
    host.write(l, 8'h3c, 8'hc3, 1'b1);
    mem[l] = 8'h3c;
    host.read(l, b);
    chk(b, 8'h3c, "dropped write");
    apb(lrm_pkg::STATUS_OFS, 1'b0, 32'h0, q, e);
    chk(q[11], 1'b1, "drop flag");
    apb(lrm_pkg::CTRL_OFS, 1'b1, 32'h0, q, e);
    apb(lrm_pkg::STATUS_OFS, 1'b0, 32'h0, q, e);
    chk(q[11], 1'b0, "drop flag clear");
    $display("test drop done");
    apb(lrm_pkg::CTRL_OFS, 1'b1, 32'h1, q, e);
    l = 6'($urandom);
    b = 8'($urandom);
    mem[l] = b;
    apb(lrm_pkg::CMD_OFS, 1'b1, cmd_word(l, b, 1'b1), q, e);
    repeat (2) @(posedge pclk);
    apb(lrm_pkg::STATUS_OFS, 1'b0, 32'h0, q, e);
    chk(q[7:0], b, "apb write");
    apb(lrm_pkg::CMD_OFS, 1'b0, 32'h0, q, e);
    chk(q, cmd_word(l, b, 1'b0), "cmd readback");
    apb(lrm_pkg::CTRL_OFS, 1'b1, 32'h0, q, e);
    $display("test apb source done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    verify_all("after reset");
    close_out();
  end
endmodule
